// ==== rtl/pwmcap_defines.svh ====
/*
  Offsets, field positions, edge codes and reset values of the edge-capture PWM submodule.
  Assumes inclusion by bare name from rtl files.
*/
`ifndef PWMCAP_DEFINES_SVH
`define PWMCAP_DEFINES_SVH

// ********************
// Register offsets
// ********************
`define PWMCAP_OFS_CTRL 12'h000
`define PWMCAP_OFS_END 12'h004
`define PWMCAP_OFS_START 12'h008
`define PWMCAP_OFS_RISE 12'h00c
`define PWMCAP_OFS_FALL 12'h010
`define PWMCAP_OFS_CAPCTRL 12'h014
`define PWMCAP_OFS_CAPCMP 12'h018
`define PWMCAP_OFS_IRQEN 12'h01c
`define PWMCAP_OFS_FLAGS 12'h020
`define PWMCAP_OFS_CAPVAL0 12'h024
`define PWMCAP_OFS_CAPVAL1 12'h028
`define PWMCAP_OFS_OUTCTL 12'h02c
`define PWMCAP_OFS_COUNT 12'h030

// ********************
// Fields
// ********************
`define PWMCAP_CTRL_RUN 0
`define PWMCAP_CAP_ARM 0
`define PWMCAP_CAP_ONESHOT 1
`define PWMCAP_CAP_EDG0_LO 2
`define PWMCAP_CAP_EDG1_LO 4
`define PWMCAP_CAP_INPSEL 6
`define PWMCAP_CAP_CNTON 7
`define PWMCAP_OUT_EN 0
`define PWMCAP_OUT_MASK 1
`define PWMCAP_OUT_POL 2
`define PWMCAP_OUT_FORCE 3

// ********************
// Edge codes and reset values
// ********************
`define PWMCAP_EDGE_FALL 2'h1
`define PWMCAP_EDGE_RISE 2'h2
`define PWMCAP_EDGE_BOTH 2'h3
`define PWMCAP_RST_END 16'hffff
`define PWMCAP_RST_CAPCMP 8'h05

`endif

// ==== rtl/pwmcap_pkg.sv ====
/*
  Types for the edge-capture PWM submodule.
  Assumes the defines header is compiled alongside.
*/
package pwmcap_pkg;
  typedef logic [15:0] pwmcap_cnt_t;
  typedef logic [31:0] pwmcap_word_t;
  typedef logic [11:0] pwmcap_addr_t;
endpackage : pwmcap_pkg

// ==== rtl/pwmcap_cap_if.sv ====
/*
  Carrier between the top and the capture engine.
  Assumes a single pclk domain.
*/
`timescale 1ns/1ps
interface pwmcap_cap_if;
  import pwmcap_pkg::*;
  logic sample;
  logic inp_sel;
  logic cnt_on;
  logic armed;
  logic [1:0] edge0;
  logic [1:0] edge1;
  logic [7:0] cmp;
  logic hit0;
  logic hit1;
  logic [7:0] edge_count;
  modport top (output sample, inp_sel, cnt_on, armed, edge0, edge1, cmp, input hit0, hit1, edge_count);
  modport eng (input sample, inp_sel, cnt_on, armed, edge0, edge1, cmp, output hit0, hit1, edge_count);
endinterface : pwmcap_cap_if

// ==== rtl/pwmcap_capture.sv ====
/*
  Capture engine: edge detection, edge counter and compare, edge-type decode.
  Assumes sample is already synchronised to pclk.
*/
`timescale 1ns/1ps
`include "pwmcap_defines.svh"
module pwmcap_capture (
  input wire logic pclk,
  input wire logic presetn,
  pwmcap_cap_if.eng cap
);
  import pwmcap_pkg::*;

  typedef struct packed {
    logic prev;
    logic [7:0] cnt;
    logic hit0;
    logic hit1;
  } pwmcap_eng_t;

  pwmcap_eng_t st_ff;
  pwmcap_eng_t nxt_st;
  logic rise;
  logic fall;
  logic cnt_edge;

  // ********************
  // Edge detection and counter
  // ********************
  always_comb begin
    rise = cap.sample & ~st_ff.prev;
    fall = ~cap.sample & st_ff.prev;
    nxt_st = st_ff;
    nxt_st.prev = cap.sample;
    nxt_st.hit0 = 1'b0;
    nxt_st.hit1 = 1'b0;
    cnt_edge = 1'b0;
    if (cap.cnt_on && (rise || fall)) begin // [RQ9] [RQ8]
      if (st_ff.cnt + 8'h01 >= cap.cmp) begin // [RQ10]
        nxt_st.cnt = 8'h00;
        cnt_edge = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + 8'h01;
      end
    end
    if (!cap.cnt_on) begin
      nxt_st.cnt = 8'h00;
    end
    if (cap.armed) begin // [RQ12]
      if (cap.inp_sel) begin // [RQ4]
        nxt_st.hit0 = cnt_edge;
        nxt_st.hit1 = cnt_edge;
      end else begin // [RQ3] [RQ5]
        nxt_st.hit0 = (rise && cap.edge0[1]) || (fall && cap.edge0[0]); // [RQ6] [RQ7]
        nxt_st.hit1 = (rise && cap.edge1[1]) || (fall && cap.edge1[0]); // [RQ6] [RQ7]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cap.hit0 = st_ff.hit0;
  assign cap.hit1 = st_ff.hit1;
  assign cap.edge_count = st_ff.cnt;

  a_rise_hit0: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
    cap.armed && !cap.inp_sel && cap.edge0 == `PWMCAP_EDGE_RISE && rise |=> st_ff.hit0)
    else $error("capture 0 missed a rising edge");
  a_fall_hit1: assert property (@(posedge pclk) disable iff (!presetn) // [RQ7]
    cap.armed && !cap.inp_sel && cap.edge1 == `PWMCAP_EDGE_FALL && fall |=> st_ff.hit1)
    else $error("capture 1 missed a falling edge");
  a_unarmed_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
    !cap.armed |=> !st_ff.hit0 && !st_ff.hit1)
    else $error("capture fired while unarmed");
  a_count_wrap: assert property (@(posedge pclk) disable iff (!presetn) // [RQ10]
    cap.armed && cap.inp_sel && cnt_edge |=> st_ff.hit0 && st_ff.cnt == 8'h00)
    else $error("edge counter compare did not fire");
endmodule : pwmcap_capture

// ==== rtl/pwmcap_top.sv ====
/*
  One PWM submodule: channel A is a PWM output, channel B an edge-capture input.
  Assumes an APB master on pclk and an asynchronous capture pin.
*/
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "pwmcap_defines.svh"

// Operation
// RQ1 - Channel A is a PWM output; channel B pin feeds capture logic
// RQ2 - Output goes high on rise compare match, low on fall compare match
// RQ3 - Source select 0 feeds raw channel B input to capture circuits
// RQ4 - Source select 1 feeds edge counter compare output to capture circuits
// RQ5 - Edge-type fields choose captured edges, only with raw source selected
// RQ6 - Edge-type value 2 captures rising edges
// RQ7 - Edge-type value 1 captures falling edges
// RQ8 - Edges counted against programmable compare, used only with counter source
// RQ9 - Edge-counter enable bit set to 1 starts the counter
// RQ10 - Compare value 5 gives one capture every 5 counted edges
// RQ11 - One-shot bit stops capture after one capture sequence
// RQ12 - Capture happens only while the arm bit is 1
// RQ13 - Separate interrupt enables per capture circuit gate the request
// RQ14 - Each circuit sets its flag; software clears by writing 1
// RQ15 - Clearing output enable tri-states the PWM pin
// RQ16 - Mask bit forces zero before polarity at next force-output event
// RQ17 - Software keeps compare values between start and end values
// RQ18 - Software changes frequency only through the end value
// RQ19 - Each capture stores the counter value in that circuit's register
// RQ20 - In one-shot mode software rearms before the next capture
module pwmcap_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire pwmcap_pkg::pwmcap_addr_t paddr,
  input wire pwmcap_pkg::pwmcap_word_t pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chan_b_in,
  output logic chan_a_out,
  output logic chan_a_oe,
  output logic chan_b_oe,
  output logic irq
);
  import pwmcap_pkg::*;

  typedef struct packed {
    logic run;
    pwmcap_cnt_t cnt;
    pwmcap_cnt_t start_val;
    pwmcap_cnt_t end_val;
    pwmcap_cnt_t rise_cmp;
    pwmcap_cnt_t fall_cmp;
    logic raw;
    logic out_en;
    logic mask;
    logic pol;
    logic mask_act;
    logic arm;
    logic oneshot;
    logic [1:0] edge0;
    logic [1:0] edge1;
    logic inp_sel;
    logic cnt_on;
    logic [7:0] cmp;
    logic ie0;
    logic ie1;
    logic flag0;
    logic flag1;
    logic done0;
    logic done1;
    pwmcap_cnt_t capval0;
    pwmcap_cnt_t capval1;
    logic sync1;
    logic sync2;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic pin;
    logic oe;
    logic irq;
  } pwmcap_top_t;

  pwmcap_top_t st_ff;
  pwmcap_top_t nxt_st;
  logic wr;
  logic rd;
  logic hit_addr;
  logic force_ev;
  logic [31:0] rd_mux;
  logic set0;
  logic set1;

  pwmcap_cap_if cap ();

  // ********************
  // Capture engine
  // ********************
  assign cap.sample = st_ff.sync2; // [RQ1]
  assign cap.inp_sel = st_ff.inp_sel;
  assign cap.cnt_on = st_ff.cnt_on;
  assign cap.armed = st_ff.arm;
  assign cap.edge0 = st_ff.edge0;
  assign cap.edge1 = st_ff.edge1;
  assign cap.cmp = st_ff.cmp;

  pwmcap_capture u_capture (
    .pclk(pclk),
    .presetn(presetn),
    .cap(cap)
  );

  // ********************
  // Register read mux
  // ********************
  always_comb begin
    hit_addr = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `PWMCAP_OFS_CTRL: rd_mux[`PWMCAP_CTRL_RUN] = st_ff.run;
      `PWMCAP_OFS_END: rd_mux[15:0] = st_ff.end_val;
      `PWMCAP_OFS_START: rd_mux[15:0] = st_ff.start_val;
      `PWMCAP_OFS_RISE: rd_mux[15:0] = st_ff.rise_cmp;
      `PWMCAP_OFS_FALL: rd_mux[15:0] = st_ff.fall_cmp;
      `PWMCAP_OFS_CAPCTRL: rd_mux[7:0] = {st_ff.cnt_on, st_ff.inp_sel, st_ff.edge1, st_ff.edge0,
                                          st_ff.oneshot, st_ff.arm};
      `PWMCAP_OFS_CAPCMP: rd_mux[15:0] = {cap.edge_count, st_ff.cmp};
      `PWMCAP_OFS_IRQEN: rd_mux[1:0] = {st_ff.ie1, st_ff.ie0};
      `PWMCAP_OFS_FLAGS: rd_mux[1:0] = {st_ff.flag1, st_ff.flag0};
      `PWMCAP_OFS_CAPVAL0: rd_mux[15:0] = st_ff.capval0;
      `PWMCAP_OFS_CAPVAL1: rd_mux[15:0] = st_ff.capval1;
      `PWMCAP_OFS_OUTCTL: rd_mux[2:0] = {st_ff.pol, st_ff.mask, st_ff.out_en};
      `PWMCAP_OFS_COUNT: rd_mux[15:0] = st_ff.cnt;
      default: hit_addr = 1'b0;
    endcase
  end

  // ********************
  // Next state
  // ********************
  always_comb begin
    wr = psel && penable && pwrite && !st_ff.ready;
    rd = psel && penable && !pwrite && !st_ff.ready;
    force_ev = wr && paddr == `PWMCAP_OFS_OUTCTL && pwdata[`PWMCAP_OUT_FORCE];
    set0 = cap.hit0 && !st_ff.done0;
    set1 = cap.hit1 && !st_ff.done1;
    nxt_st = st_ff;
    nxt_st.sync1 = chan_b_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.ready = wr || rd;
    nxt_st.err = (wr || rd) && !hit_addr;
    if (rd) begin
      nxt_st.rdata = rd_mux;
    end
    // PWM counter
    if (st_ff.run) begin
      if (st_ff.cnt >= st_ff.end_val) begin
        nxt_st.cnt = st_ff.start_val;
      end else begin
        nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
    end else begin
      nxt_st.cnt = st_ff.start_val;
    end
    if (st_ff.run && st_ff.cnt == st_ff.rise_cmp) begin
      nxt_st.raw = 1'b1; // [RQ2]
    end else if (st_ff.run && st_ff.cnt == st_ff.fall_cmp) begin
      nxt_st.raw = 1'b0; // [RQ2]
    end
    // Captures
    if (set0) begin
      nxt_st.capval0 = st_ff.cnt; // [RQ19]
      nxt_st.done0 = st_ff.oneshot; // [RQ11]
    end
    if (set1) begin
      nxt_st.capval1 = st_ff.cnt; // [RQ19]
      nxt_st.done1 = st_ff.oneshot; // [RQ11]
    end
    if (st_ff.oneshot && (nxt_st.done0 || !(st_ff.edge0 != 2'h0 || st_ff.inp_sel)) &&
        (nxt_st.done1 || !(st_ff.edge1 != 2'h0 || st_ff.inp_sel)) && (set0 || set1)) begin
      nxt_st.arm = 1'b0; // [RQ11] [RQ20]
    end
    // Register writes
    if (wr) begin
      unique case (paddr)
        `PWMCAP_OFS_CTRL: nxt_st.run = pwdata[`PWMCAP_CTRL_RUN];
        `PWMCAP_OFS_END: nxt_st.end_val = pwdata[15:0];
        `PWMCAP_OFS_START: nxt_st.start_val = pwdata[15:0];
        `PWMCAP_OFS_RISE: nxt_st.rise_cmp = pwdata[15:0];
        `PWMCAP_OFS_FALL: nxt_st.fall_cmp = pwdata[15:0];
        `PWMCAP_OFS_CAPCTRL: begin
          nxt_st.arm = pwdata[`PWMCAP_CAP_ARM];
          nxt_st.oneshot = pwdata[`PWMCAP_CAP_ONESHOT];
          nxt_st.edge0 = pwdata[`PWMCAP_CAP_EDG0_LO +: 2];
          nxt_st.edge1 = pwdata[`PWMCAP_CAP_EDG1_LO +: 2];
          nxt_st.inp_sel = pwdata[`PWMCAP_CAP_INPSEL];
          nxt_st.cnt_on = pwdata[`PWMCAP_CAP_CNTON];
          nxt_st.done0 = 1'b0;
          nxt_st.done1 = 1'b0;
        end
        `PWMCAP_OFS_CAPCMP: nxt_st.cmp = pwdata[7:0];
        `PWMCAP_OFS_IRQEN: begin
          nxt_st.ie0 = pwdata[0]; // [RQ13]
          nxt_st.ie1 = pwdata[1]; // [RQ13]
        end
        `PWMCAP_OFS_FLAGS: begin
          nxt_st.flag0 = st_ff.flag0 & ~pwdata[0]; // [RQ14]
          nxt_st.flag1 = st_ff.flag1 & ~pwdata[1]; // [RQ14]
        end
        `PWMCAP_OFS_OUTCTL: begin
          nxt_st.out_en = pwdata[`PWMCAP_OUT_EN];
          nxt_st.mask = pwdata[`PWMCAP_OUT_MASK];
          nxt_st.pol = pwdata[`PWMCAP_OUT_POL];
        end
        default: begin
        end
      endcase
    end
    if (set0) begin
      nxt_st.flag0 = 1'b1; // [RQ14]
    end
    if (set1) begin
      nxt_st.flag1 = 1'b1; // [RQ14]
    end
    if (force_ev) begin
      nxt_st.mask_act = pwdata[`PWMCAP_OUT_MASK]; // [RQ16]
    end
    nxt_st.pin = (nxt_st.raw & ~nxt_st.mask_act) ^ nxt_st.pol; // [RQ16]
    nxt_st.oe = nxt_st.out_en; // [RQ15]
    nxt_st.irq = (nxt_st.flag0 & nxt_st.ie0) | (nxt_st.flag1 & nxt_st.ie1); // [RQ13]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.end_val <= `PWMCAP_RST_END;
      st_ff.cmp <= `PWMCAP_RST_CAPCMP;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ********************
  // Outputs
  // ********************
  assign prdata = st_ff.rdata;
  assign pready = st_ff.ready;
  assign pslverr = st_ff.err;
  assign chan_a_out = st_ff.pin;
  assign chan_a_oe = st_ff.oe;
  assign chan_b_oe = 1'b0; // [RQ1]
  assign irq = st_ff.irq;

  // ********************
  // Checks
  // ********************
  sequence s_flag_write(int b);
    wr && paddr == `PWMCAP_OFS_FLAGS && pwdata[b];
  endsequence

  sequence s_outctl_write;
    wr && paddr == `PWMCAP_OFS_OUTCTL;
  endsequence

  // ********************
  // Flag, capture and interrupt checks
  // ********************
  a_flag_sets: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14] [RQ19]
    set0 |=> st_ff.flag0 && st_ff.capval0 == $past(st_ff.cnt))
    else $error("capture 0 flag or value not stored");
  a_flag1_sets: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14] [RQ19]
    set1 |=> st_ff.flag1 && st_ff.capval1 == $past(st_ff.cnt))
    else $error("capture 1 flag or value not stored");
  a_flag_clears: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
    s_flag_write(1) ##0 !set1 |=> !st_ff.flag1)
    else $error("flag 1 not cleared by write of one");
  a_flag0_clears: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
    s_flag_write(0) ##0 !set0 |=> !st_ff.flag0)
    else $error("flag 0 not cleared by write of one");
  a_clear_loses: assert property (@(posedge pclk) disable iff (!presetn) // [RQ14]
    s_flag_write(0) ##0 set0 |=> st_ff.flag0)
    else $error("clear won over a new capture");
  a_capval_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RQ19]
    !set0 |=> $stable(st_ff.capval0))
    else $error("capture 0 value changed without a capture");
  a_oneshot_hold: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
    st_ff.done0 && !wr |=> $stable(st_ff.capval0))
    else $error("one-shot captured twice");
  a_oneshot_disarm: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
    st_ff.oneshot && set0 && st_ff.edge1 == 2'h0 && !st_ff.inp_sel && !wr |=> !st_ff.arm)
    else $error("one-shot did not disarm");
  a_irq_gated: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
    !st_ff.ie0 && !st_ff.ie1 |-> !irq)
    else $error("interrupt without enable");
  a_irq_raised: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
    st_ff.flag0 && st_ff.ie0 |-> irq)
    else $error("enabled capture 0 flag without interrupt");
  a_irq_quiet: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
    !st_ff.flag0 && !st_ff.flag1 |-> !irq)
    else $error("interrupt without a flag");

  // ********************
  // Output checks
  // ********************
  a_oe_follows: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
    !st_ff.out_en |-> !chan_a_oe)
    else $error("pin driven while output disabled");
  a_oe_drives: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
    st_ff.out_en |-> chan_a_oe)
    else $error("pin not driven while output enabled");
  a_mask_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
    st_ff.mask_act |-> chan_a_out == st_ff.pol)
    else $error("masked output not forced to zero");
  a_force_mask: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
    force_ev |=> st_ff.mask_act == $past(pwdata[`PWMCAP_OUT_MASK]))
    else $error("force event did not apply the mask");
  a_mask_waits: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
    s_outctl_write ##0 !pwdata[`PWMCAP_OUT_FORCE] |=> $stable(st_ff.mask_act))
    else $error("mask applied without a force event");
  a_rise_edge: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
    st_ff.run && st_ff.cnt == st_ff.rise_cmp |=> st_ff.raw)
    else $error("output not high after rise compare");
  a_fall_edge: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
    st_ff.run && st_ff.cnt == st_ff.fall_cmp && st_ff.cnt != st_ff.rise_cmp |=> !st_ff.raw)
    else $error("output not low after fall compare");

  // ********************
  // APB checks
  // ********************
  a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("APB access not answered in one cycle");
  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");
  a_ready_access: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(psel && penable))
    else $error("pready without an access phase");
endmodule : pwmcap_top

// ==== tb/pwmcap_pin_model.sv ====
/*
  Far-side source for the capture pin: a plain digital signal.
  Assumes the bench calls move_pin from its main sequence.
*/
`timescale 1ns/1ps
// ********************
// Pin source
// ********************
module pwmcap_pin_model (
  input wire logic pclk,
  output logic pin
);
  initial begin
    pin = 1'b0;
  end
  // Waits a number of cycles, then moves the pin
  task automatic move_pin(input logic lvl, input int gap);
    repeat (gap) @(posedge pclk);
    pin <= lvl;
  endtask : move_pin
endmodule : pwmcap_pin_model

// ==== tb/tb_pwmcap_top.sv ====
/*
  Self-checking bench for the edge-capture PWM submodule.
  Assumes the design files and the pin model are compiled first.
*/
`timescale 1ns/1ps
`include "pwmcap_defines.svh"
module tb_pwmcap_top;
  import pwmcap_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  pwmcap_addr_t paddr = 12'h000;
  pwmcap_word_t pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic chan_b_in;
  logic chan_a_out;
  logic chan_a_oe;
  logic chan_b_oe;
  logic irq;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  logic lvl = 1'b0;
  logic [31:0] rd;
  logic err;
  logic [31:0] hi;
  always #12.5 pclk = ~pclk;
  pwmcap_top u_pwmcap_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_b_in(chan_b_in), .chan_a_out(chan_a_out), .chan_a_oe(chan_a_oe), .chan_b_oe(chan_b_oe), .irq(irq));
  pwmcap_pin_model u_pwmcap_pin_model (.pclk(pclk), .pin(chan_b_in));
  // ********************
  // Tasks
  // ********************
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic is_wr, input pwmcap_addr_t a, input pwmcap_word_t d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input pwmcap_addr_t a, input pwmcap_word_t d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rchk(input pwmcap_addr_t a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rchk
  // Moves the pin, then lets the capture path settle
  task automatic pin(input logic v);
    lvl = v;
    u_pwmcap_pin_model.move_pin(v, 2);
    repeat (8) @(posedge pclk);
  endtask : pin
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // ********************
  // Tests
  // ********************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rchk(`PWMCAP_OFS_END, 32'h0000ffff);
    chk({31'h0, err}, 32'h0);
    rchk(`PWMCAP_OFS_CAPCMP, 32'h00000005);
    chk({31'h0, chan_b_oe}, 32'h0);
    rchk(12'h0fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    wr(`PWMCAP_OFS_END, 32'h13);
    wr(`PWMCAP_OFS_RISE, 32'h5);
    wr(`PWMCAP_OFS_FALL, 32'ha);
    wr(`PWMCAP_OFS_OUTCTL, 32'h1);
    wr(`PWMCAP_OFS_CTRL, 32'h1);
    chk({31'h0, chan_a_oe}, 32'h1);
    hi = 0;
    repeat (40) @(negedge pclk) hi += chan_a_out;
    chk(hi, 32'ha);
    wr(`PWMCAP_OFS_IRQEN, 32'h3);
    wr(`PWMCAP_OFS_CAPCTRL, 32'h19);
    pin(1'b1);
    rchk(`PWMCAP_OFS_FLAGS, 32'h1);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, `PWMCAP_OFS_CAPVAL0, 32'h0);
    chk({31'h0, rd < 32'h14}, 32'h1);
    pin(1'b0);
    rchk(`PWMCAP_OFS_FLAGS, 32'h3);
    wr(`PWMCAP_OFS_FLAGS, 32'h3);
    rchk(`PWMCAP_OFS_FLAGS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`PWMCAP_OFS_IRQEN, 32'h2);
    pin(1'b1);
    rchk(`PWMCAP_OFS_FLAGS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(`PWMCAP_OFS_FLAGS, 32'h1);
    wr(`PWMCAP_OFS_CAPCTRL, 32'h18);
    pin(1'b0);
    rchk(`PWMCAP_OFS_FLAGS, 32'h0);
    wr(`PWMCAP_OFS_CAPCTRL, 32'h0b);
    pin(1'b1);
    rchk(`PWMCAP_OFS_FLAGS, 32'h1);
    rchk(`PWMCAP_OFS_CAPCTRL, 32'h0a);
    wr(`PWMCAP_OFS_FLAGS, 32'h1);
    pin(1'b0);
    pin(1'b1);
    rchk(`PWMCAP_OFS_FLAGS, 32'h0);
    wr(`PWMCAP_OFS_CAPCTRL, 32'h0b);
    pin(1'b0);
    pin(1'b1);
    rchk(`PWMCAP_OFS_FLAGS, 32'h1);
    wr(`PWMCAP_OFS_FLAGS, 32'h1);
    wr(`PWMCAP_OFS_CAPCTRL, 32'hc1);
    repeat (4) pin(~lvl);
    rchk(`PWMCAP_OFS_FLAGS, 32'h0);
    rchk(`PWMCAP_OFS_CAPCMP, 32'h0405);
    pin(~lvl);
    rchk(`PWMCAP_OFS_FLAGS, 32'h3);
    wr(`PWMCAP_OFS_FLAGS, 32'h3);
    wr(`PWMCAP_OFS_CAPCTRL, 32'h0d);
    pin(~lvl);
    rchk(`PWMCAP_OFS_FLAGS, 32'h1);
    wr(`PWMCAP_OFS_FLAGS, 32'h1);
    pin(~lvl);
    rchk(`PWMCAP_OFS_FLAGS, 32'h1);
    apb(1'b0, `PWMCAP_OFS_CAPVAL1, 32'h0);
    chk({31'h0, rd < 32'h14}, 32'h1);
    wr(`PWMCAP_OFS_OUTCTL, 32'h3);
    hi = 32'h0;
    repeat (40) @(negedge pclk) hi += chan_a_out;
    chk(hi, 32'ha);
    wr(`PWMCAP_OFS_OUTCTL, 32'hb);
    hi = 32'h0;
    repeat (40) @(negedge pclk) hi += chan_a_out;
    chk(hi, 32'h0);
    wr(`PWMCAP_OFS_OUTCTL, 32'hf);
    hi = 32'h0;
    repeat (40) @(negedge pclk) hi += chan_a_out;
    chk(hi, 32'h28);
    chk({31'h0, chan_a_oe}, 32'h1);
    wr(`PWMCAP_OFS_OUTCTL, 32'h0);
    repeat (2) @(posedge pclk);
    chk({31'h0, chan_a_oe}, 32'h0);
    summarize();
  end
endmodule : tb_pwmcap_top
